// ===== pkg/hgtp_defs.vh
// constants for the hdr gain and test pattern path
`ifndef HGTP_DEFS_VH
`define HGTP_DEFS_VH
// register addresses
`define HGTP_ADDR_HOLD  16'h0104
`define HGTP_ADDR_CGAIN 16'h212C
`define HGTP_ADDR_AGAIN 16'h0204
`define HGTP_ADDR_BASE  16'h3000
`define HGTP_ADDR_LAST  16'h3019
`define HGTP_ADDR_STAT  16'h301A
// shadowed register indexes
`define HGTP_NREG       28
`define HGTP_IDX_CGAIN  5'h00
`define HGTP_IDX_AGAIN  5'h01
`define HGTP_IDX_BASE   5'h02
`define HGTP_IDX_WB     5'h02
`define HGTP_IDX_OG     5'h0A
`define HGTP_IDX_SOLID  5'h12
`define HGTP_IDX_RAMP   5'h1A
`define HGTP_IDX_TPC    5'h1B
// reset values
`define HGTP_GAIN_HI_RST 8'h01
`define HGTP_TPC_RST     8'h20
// pattern control fields
`define HGTP_KIND_MSB   4
`define HGTP_MODE_LSB   5
`define HGTP_MODE_MSB   6
`define HGTP_MODE_STD   2'h0
`define HGTP_MODE_SAFE  2'h1
`define HGTP_MODE_RAMP  2'h2
`define HGTP_KIND_NONE  5'h00
`define HGTP_KIND_SOLID 5'h01
`define HGTP_KIND_BARS  5'h02
`define HGTP_KIND_FADE  5'h03
`define HGTP_KIND_HRAMP 5'h10
`define HGTP_KIND_VRAMP 5'h11
`define HGTP_KIND_DRAMP 5'h12
`define HGTP_KIND_PRBS  5'h13
`define HGTP_KIND_SMEAR 5'h14
// bayer channel codes
`define HGTP_CH_R       2'h1
`define HGTP_CH_B       2'h2
// timing and pixel constants
`define HGTP_CUTOFF_LINES 16'h009F
`define HGTP_FULL       12'hFFF
`define HGTP_BAR_LSB    8
`define HGTP_SMEAR_LO   12'h100
`define HGTP_SMEAR_HI   12'h1FF
`define HGTP_PRBS_SEED  28'h000_0001
`endif

// ===== verilog/hgtp_path.v
// gain, retiming and test pattern logic of the hdr pixel path
`default_nettype none
`include "hgtp_defs.vh"
// What this block does
// - one analog gain for all three exposures
// - long readout through x1 and x4 converters
// - merge both long streams into 12 bits
// - 8-bit gain register, low nibble coarse code
// - white balance gains and output gains
// - four 16-bit gains, one per bayer channel
// - gains are unsigned 8.8 fixed point
// - conversion gain register selects high/low gain
// - writes 159 lines before frame start apply
// - hold bit defers updates, release applies together
// - patterns injected per exposure before merge
// - three generator modes from mode field
// - safety-line ramp mode is reset default
// - hdr ramp over programmable number of lines
// - pattern control applies on standby-to-stream only
// - standard mode selects nine pattern kinds
// - smear replaces rectangle, passes rest through
// - eight full-scale bayer colour bars
// - fading bars, smooth left, quantized right half
// - quantized lsbs copy msbs, repeat 256 lines

////////////////////////////////////////////////////////////////
// pixel fifo, storage in flip-flops
module hgtp_fifo #(
	parameter WIDTH = 38,
	parameter DEPTH = 16,
	parameter AW    = 4
) (
	// clock and reset
	input  wire             clock,
	input  wire             resetn,
	// fill side
	input  wire             inValid,
	output wire             inReady,
	input  wire [WIDTH-1:0] inData,
	// drain side
	output wire             outValid,
	input  wire             outReady,
	output wire [WIDTH-1:0] outData
);
	reg  [WIDTH-1:0] mem [0:DEPTH-1];
	reg  [AW-1:0]    wrPtr;
	reg  [AW-1:0]    rdPtr;
	reg  [AW:0]      count;
	wire             doWr;
	wire             doRd;
	// full and empty straight from the fill count, sized to the counter
	assign inReady  = (count != DEPTH[AW:0]);
	assign outValid = (count != {(AW+1){1'b0}});
	assign outData  = mem[rdPtr];
	assign doWr     = inValid && inReady;
	assign doRd     = outValid && outReady;
	// pointers and count
	always @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			wrPtr <= {AW{1'b0}};
			rdPtr <= {AW{1'b0}};
			count <= {(AW+1){1'b0}};
		end else begin
			if (doWr)
				wrPtr <= wrPtr + 1'b1;
			if (doRd)
				rdPtr <= rdPtr + 1'b1;
			if (doWr && !doRd)
				count <= count + 1'b1;
			else if (doRd && !doWr)
				count <= count - 1'b1;
		end
	end
	// storage has no reset, only written words are ever read
	always @(posedge clock) begin
		if (doWr)
			mem[wrPtr] <= inData;
	end
endmodule

////////////////////////////////////////////////////////////////
// top of the gain and pattern path
module hgtp_path (
	// clock and reset
	input  wire        clock,
	input  wire        resetn,
	// register port from the control interface
	input  wire        regWrEn,
	input  wire        regRdEn,
	input  wire [15:0] regAddr,
	input  wire [7:0]  regWrData,
	output reg  [7:0]  regRdData,
	// frame timing
	input  wire        frameStart,
	input  wire        lineStart,
	input  wire [15:0] frameLenLines,
	input  wire        streamOn,
	// analog controls
	output wire [3:0]  coarseGainCode,
	output wire        convGainHigh,
	// pixel input
	input  wire        pixValid,
	output wire        pixReady,
	input  wire [11:0] pixUnity,
	input  wire [11:0] pixQuad,
	input  wire [11:0] pixMedium,
	input  wire [11:0] pixShort,
	input  wire [1:0]  pixChan,
	input  wire [11:0] pixX,
	input  wire [11:0] pixY,
	input  wire        pixSafetyLine,
	// pixel output
	output wire        outValid,
	input  wire        outReady,
	output wire [11:0] outLong,
	output wire [11:0] outMedium,
	output wire [11:0] outShort,
	output wire [1:0]  outChan,
	// merged pixel gain stage
	input  wire        mergeValid,
	input  wire [11:0] mergeIn,
	input  wire [1:0]  mergeChan,
	output reg         mergeOutValid,
	output reg  [11:0] mergeOut
);
	reg  [7:0]  pendReg  [0:`HGTP_NREG-1];
	reg  [7:0]  stageReg [0:`HGTP_NREG-1];
	reg  [7:0]  liveReg  [0:`HGTP_NREG-1];
	reg  [7:0]  holdReg;
	reg         stageValid;
	reg         streamPrev;
	reg  [15:0] lineInFrame;
	reg  [27:0] prbs;
	reg  [11:0] patVal;
	reg         patOn;
	reg  [11:0] fadeVal;
	reg         barOn;
	integer     i;
	wire [5:0]  decode;
	wire        wrHit;
	wire        cutoff;
	wire        streamRise;
	wire        pixTake;
	wire [7:0]  tpc;
	wire [1:0]  tpMode;
	wire [4:0]  tpKind;
	wire [4:0]  wbIdx;
	wire [4:0]  ogIdx;
	wire [4:0]  solIdx;
	wire [11:0] solidVal;
	wire [11:0] longMerged;
	wire [11:0] longSel;
	wire [11:0] medSel;
	wire [11:0] shortSel;
	wire [15:0] wbGain;
	wire        inRect;
	wire [11:0] diag;
	wire [11:0] fadeQuant;
	// address to shadow index, bit 5 marks a hit
	function [5:0] addrIdx;
		input [15:0] a;
		reg   [15:0] off;
		begin
			off = a - `HGTP_ADDR_BASE;
			if (a == `HGTP_ADDR_CGAIN)
				addrIdx = {1'b1, `HGTP_IDX_CGAIN};
			else if (a == `HGTP_ADDR_AGAIN)
				addrIdx = {1'b1, `HGTP_IDX_AGAIN};
			else if (a >= `HGTP_ADDR_BASE && a <= `HGTP_ADDR_LAST)
				addrIdx = {1'b1, off[4:0] + `HGTP_IDX_BASE};
			else
				addrIdx = 6'h00;
		end
	endfunction
	// 8.8 gain, saturating to the 12-bit range
	function [11:0] applyGain;
		input [11:0] v;
		input [15:0] g;
		reg   [27:0] p;
		begin
			p = v * g;
			if (|p[27:20])
				applyGain = `HGTP_FULL;
			else
				applyGain = p[19:8];
		end
	endfunction
	assign decode = addrIdx(regAddr);
	assign wrHit  = regWrEn && decode[5];

	////////////////////////////////////////////////////////////
	// frame retiming: pending -> staged at cutoff -> live at frame start
	assign cutoff = lineStart &&
		(lineInFrame == frameLenLines - `HGTP_CUTOFF_LINES);
	assign streamRise = streamOn && !streamPrev;

	// line counter restarts on every frame start
	always @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			lineInFrame <= 16'h0000;
			streamPrev  <= 1'b0;
		end else begin
			streamPrev <= streamOn;
			if (frameStart)
				lineInFrame <= 16'h0000;
			else if (lineStart)
				lineInFrame <= lineInFrame + 16'h0001;
		end
	end

	// register file with its three copies
	always @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			holdReg    <= 8'h00;
			stageValid <= 1'b0;
			for (i = 0; i < `HGTP_NREG; i = i + 1) begin
				pendReg[i]  <= 8'h00;
				stageReg[i] <= 8'h00;
				liveReg[i]  <= 8'h00;
			end
			// unity digital gains out of reset
			for (i = 0; i < 8; i = i + 2) begin
				pendReg[`HGTP_IDX_WB+i]  <= `HGTP_GAIN_HI_RST;
				stageReg[`HGTP_IDX_WB+i] <= `HGTP_GAIN_HI_RST;
				liveReg[`HGTP_IDX_WB+i]  <= `HGTP_GAIN_HI_RST;
				pendReg[`HGTP_IDX_OG+i]  <= `HGTP_GAIN_HI_RST;
				stageReg[`HGTP_IDX_OG+i] <= `HGTP_GAIN_HI_RST;
				liveReg[`HGTP_IDX_OG+i]  <= `HGTP_GAIN_HI_RST;
			end
			pendReg[`HGTP_IDX_TPC] <= `HGTP_TPC_RST;
			liveReg[`HGTP_IDX_TPC] <= `HGTP_TPC_RST;
		end else begin
			if (regWrEn && regAddr == `HGTP_ADDR_HOLD)
				holdReg <= regWrData;
			if (wrHit)
				pendReg[decode[4:0]] <= regWrData;
			// hold bit freezes the whole set until released
			if (cutoff && !holdReg[0]) begin
				stageValid <= 1'b1;
				for (i = 0; i < `HGTP_IDX_TPC; i = i + 1)
					stageReg[i] <= pendReg[i];
			end else if (frameStart && stageValid) begin
				stageValid <= 1'b0;
			end
			if (frameStart && stageValid) begin
				for (i = 0; i < `HGTP_IDX_TPC; i = i + 1)
					liveReg[i] <= stageReg[i];
			end
			// pattern control only moves on entering video_out_state
			if (streamRise)
				liveReg[`HGTP_IDX_TPC] <= pendReg[`HGTP_IDX_TPC];
		end
	end

	// readback of pending values and block status
	always @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			regRdData <= 8'h00;
		end else if (regRdEn) begin
			if (regAddr == `HGTP_ADDR_HOLD)
				regRdData <= holdReg;
			else if (regAddr == `HGTP_ADDR_STAT)
				regRdData <= {6'h00, streamPrev, stageValid};
			else if (decode[5])
				regRdData <= pendReg[decode[4:0]];
			else
				regRdData <= 8'h00;
		end
	end

	////////////////////////////////////////////////////////////
	// analog controls, one code for all exposures
	assign coarseGainCode = liveReg[`HGTP_IDX_AGAIN][3:0];
	assign convGainHigh   = liveReg[`HGTP_IDX_CGAIN][0];

	// x4 stream is used until it clips, then unity takes over
	assign longMerged = (pixQuad != `HGTP_FULL) ?
		{2'b00, pixQuad[11:2]} : pixUnity;

	////////////////////////////////////////////////////////////
	// test pattern generator
	assign tpc      = liveReg[`HGTP_IDX_TPC];
	assign tpMode   = tpc[`HGTP_MODE_MSB:`HGTP_MODE_LSB];
	assign tpKind   = tpc[`HGTP_KIND_MSB:0];
	assign solIdx   = `HGTP_IDX_SOLID + {2'b00, pixChan, 1'b0};
	assign solidVal = {liveReg[solIdx][3:0], liveReg[solIdx+5'h01]};
	assign diag     = pixX + pixY;
	assign pixTake  = pixValid && pixReady;
	assign inRect   = pixX >= `HGTP_SMEAR_LO && pixX <= `HGTP_SMEAR_HI &&
		pixY >= `HGTP_SMEAR_LO && pixY <= `HGTP_SMEAR_HI;
	// lsbs refilled from msbs so flat fields keep full swing
	assign fadeQuant = {fadeVal[11:6], fadeVal[11:6]};

	// prbs restarts from the same seed at every frame
	always @(posedge clock or negedge resetn) begin
		if (!resetn)
			prbs <= `HGTP_PRBS_SEED;
		else if (frameStart)
			prbs <= `HGTP_PRBS_SEED;
		else if (pixTake)
			prbs <= {prbs[26:0], prbs[27] ^ prbs[24]};
	end

	// bar colour from bar index and bayer channel
	always @* begin
		case (pixChan)
			`HGTP_CH_R: barOn = ~pixX[`HGTP_BAR_LSB+1];
			`HGTP_CH_B: barOn = ~pixX[`HGTP_BAR_LSB];
			default:    barOn = ~pixX[`HGTP_BAR_LSB+2];
		endcase
		// fade toward mid grey over 256 lines
		if (barOn)
			fadeVal = `HGTP_FULL - {1'b0, pixY[7:0], 3'h0};
		else
			fadeVal = {1'b0, pixY[7:0], 3'h0};
	end

	// pattern value and whether it replaces the image
	always @* begin
		patOn  = 1'b0;
		patVal = 12'h000;
		case (tpMode)
			`HGTP_MODE_SAFE: begin
				patOn  = pixSafetyLine;
				patVal = pixX;
			end
			`HGTP_MODE_RAMP: begin
				patOn  = pixY < {4'h0, liveReg[`HGTP_IDX_RAMP]};
				patVal = pixX;
			end
			`HGTP_MODE_STD: begin
				patOn = 1'b1;
				case (tpKind)
					`HGTP_KIND_SOLID: patVal = solidVal;
					`HGTP_KIND_BARS:
						patVal = barOn ? `HGTP_FULL : 12'h000;
					`HGTP_KIND_FADE:
						patVal = pixX[`HGTP_BAR_LSB-1] ? fadeQuant : fadeVal;
					`HGTP_KIND_HRAMP: patVal = pixX;
					`HGTP_KIND_VRAMP: patVal = pixY;
					`HGTP_KIND_DRAMP: patVal = diag;
					`HGTP_KIND_PRBS:  patVal = prbs[11:0];
					`HGTP_KIND_SMEAR: begin
						patOn  = inRect;
						patVal = solidVal;
					end
					default: patOn = 1'b0;
				endcase
			end
			default: patOn = 1'b0;
		endcase
	end

	// injection into each exposure path ahead of the merge
	assign longSel  = patOn ? patVal : longMerged;
	assign medSel   = patOn ? patVal : pixMedium;
	assign shortSel = patOn ? patVal : pixShort;

	////////////////////////////////////////////////////////////
	// white balance gain on long and medium, then buffering
	assign wbIdx  = `HGTP_IDX_WB + {2'b00, pixChan, 1'b0};
	assign wbGain = {liveReg[wbIdx], liveReg[wbIdx+5'h01]};

	// a full fifo stalls the pixel source
	hgtp_fifo #(
		.WIDTH (38),
		.DEPTH (16),
		.AW    (4)
	) pixFifo (
		.clock    (clock),
		.resetn   (resetn),
		.inValid  (pixValid),
		.inReady  (pixReady),
		.inData   ({applyGain(longSel, wbGain),
			applyGain(medSel, wbGain), shortSel, pixChan}),
		.outValid (outValid),
		.outReady (outReady),
		.outData  ({outLong, outMedium, outShort, outChan})
	);

	// output gain stage on the merged pixel
	assign ogIdx = `HGTP_IDX_OG + {2'b00, mergeChan, 1'b0};
	always @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			mergeOutValid <= 1'b0;
			mergeOut      <= 12'h000;
		end else begin
			mergeOutValid <= mergeValid;
			if (mergeValid)
				mergeOut <= applyGain(mergeIn,
					{liveReg[ogIdx], liveReg[ogIdx+5'h01]});
		end
	end
endmodule
`default_nettype wire

// ===== test/hgtp_host_model.sv
// host model driving the register port of the pixel path
`default_nettype none
`include "hgtp_defs.vh"
module hgtp_host_model (
	// clock
	input  wire logic        clock,
	// register port
	output var  logic        regWrEn,
	output var  logic        regRdEn,
	output var  logic [15:0] regAddr,
	output var  logic [7:0]  regWrData,
	input  wire logic [7:0]  regRdData
);
	timeunit 1ns;
	timeprecision 1ns;
	// idle bus at time zero
	initial begin
		regWrEn = 1'b0;
		regRdEn = 1'b0;
		regAddr = 16'h0000;
		regWrData = 8'h00;
	end
	// one byte write; the address is scrambled once released
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge clock);
		#1;
		regAddr = a;
		regWrData = d;
		regWrEn = 1'b1;
		@(posedge clock);
		#1;
		regWrEn = 1'b0;
		regAddr = ~a;
		regWrData = ~d;
	endtask
	// one byte read, data taken after the read edge
	task automatic rd(input logic [15:0] a, output logic [7:0] d);
		@(posedge clock);
		#1;
		regAddr = a;
		regRdEn = 1'b1;
		@(posedge clock);
		#1;
		regRdEn = 1'b0;
		regAddr = ~a;
		d = regRdData;
	endtask
	// open a grouped update; the caller clears the hold bit afterwards
	task automatic stage(input logic [3:0] c, input logic cg, input logic [15:0] og);
		wr(`HGTP_ADDR_HOLD, 8'h01);
		wr(`HGTP_ADDR_AGAIN, {4'h0, (c > 4'hC) ? 4'hC : c});
		wr(`HGTP_ADDR_CGAIN, {7'h00, cg});
		wr(16'h300A, og[15:8]);
		wr(16'h300B, og[7:0]);
	endtask
endmodule
`default_nettype wire

// ===== test/hgtp_path_monitor.sv
// concurrent checks on the pixel path ports
`default_nettype none
module hgtp_path_monitor (
	input wire logic        clock,
	input wire logic        resetn,
	input wire logic        regRdEn,
	input wire logic [7:0]  regRdData,
	input wire logic        frameStart,
	input wire logic [3:0]  coarseGainCode,
	input wire logic        convGainHigh,
	input wire logic        pixReady,
	input wire logic        outValid,
	input wire logic        outReady,
	input wire logic [11:0] outLong,
	input wire logic        mergeValid,
	input wire logic [11:0] mergeIn,
	input wire logic        mergeOutValid,
	input wire logic [11:0] mergeOut
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge clock); endclocking
	default disable iff (!resetn);
	property p_mg; mergeValid |=> mergeOutValid; endproperty
	a_mg: assert property (p_mg) else $error("merge pulse missing");
	property p_nmg; !mergeValid |=> !mergeOutValid; endproperty
	a_nmg: assert property (p_nmg) else $error("stray merge pulse");
	property p_zero; mergeValid && mergeIn == 12'h000 |=> mergeOut == 12'h000; endproperty
	a_zero: assert property (p_zero) else $error("zero not kept");
	property p_cg; !frameStart |=> $stable(convGainHigh); endproperty
	a_cg: assert property (p_cg) else $error("conv gain off frame");
	property p_ag; !frameStart |=> $stable(coarseGainCode); endproperty
	a_ag: assert property (p_ag) else $error("gain code off frame");
	property p_rd; !regRdEn |=> $stable(regRdData); endproperty
	a_rd: assert property (p_rd) else $error("read data moved");
	property p_full; !pixReady |-> outValid; endproperty
	a_full: assert property (p_full) else $error("refused while empty");
	property p_hold; outValid && !outReady |=> outValid && $stable(outLong); endproperty
	a_hold: assert property (p_hold) else $error("output lost");
	// main scenarios reached
	c_full: cover property (!pixReady);
	c_mg: cover property (mergeValid ##1 mergeOutValid);
	c_fs: cover property (frameStart);
endmodule
bind hgtp_path hgtp_path_monitor mon (.clock(clock), .resetn(resetn), .regRdEn(regRdEn),
	.regRdData(regRdData), .frameStart(frameStart), .coarseGainCode(coarseGainCode),
	.convGainHigh(convGainHigh), .pixReady(pixReady), .outValid(outValid),
	.outReady(outReady), .outLong(outLong), .mergeValid(mergeValid), .mergeIn(mergeIn),
	.mergeOutValid(mergeOutValid), .mergeOut(mergeOut));
`default_nettype wire

// ===== test/hgtp_path_test.sv
// self-checking bench for the pixel path
`default_nettype none
`include "hgtp_defs.vh"
module hgtp_path_test;
	timeunit 1ns;
	timeprecision 1ns;
	logic        clock, resetn, regWrEn, regRdEn, frameStart, lineStart, streamOn;
	logic        convGainHigh, pixValid, pixReady, pixSafetyLine, outValid, outReady;
	logic        mergeValid, mergeOutValid;
	logic [15:0] regAddr, frameLenLines;
	logic [7:0]  regWrData, regRdData, d;
	logic [3:0]  coarseGainCode;
	logic [11:0] pixUnity, pixQuad, pixMedium, pixShort, pixX, pixY;
	logic [11:0] outLong, outMedium, outShort, mergeIn, mergeOut;
	logic [1:0]  pixChan, outChan, mergeChan;
	int          err_total, comparisons, cyc;
	logic [7:0]  cTab [11] = '{8'h00, 8'h01, 8'h02, 8'h02, 8'h03, 8'h14, 8'h14, 8'h40,
		8'h10, 8'h11, 8'h12};
	logic [11:0] xTab [11] = '{12'h300, 12'h300, 12'h000, 12'h700, 12'h080, 12'h180,
		12'h300, 12'h300, 12'h123, 12'h123, 12'h123};
	logic [11:0] eTab [11] = '{12'h010, 12'h000, 12'hFFF, 12'h000, 12'hBEF, 12'h000,
		12'h010, 12'h010, 12'h123, 12'h123, 12'h246};
	hgtp_host_model host (.clock(clock), .regWrEn(regWrEn), .regRdEn(regRdEn),
		.regAddr(regAddr), .regWrData(regWrData), .regRdData(regRdData));
	hgtp_path dut (.clock(clock), .resetn(resetn), .regWrEn(regWrEn), .regRdEn(regRdEn),
		.regAddr(regAddr), .regWrData(regWrData), .regRdData(regRdData),
		.frameStart(frameStart), .lineStart(lineStart), .frameLenLines(frameLenLines),
		.streamOn(streamOn), .coarseGainCode(coarseGainCode), .convGainHigh(convGainHigh),
		.pixValid(pixValid), .pixReady(pixReady), .pixUnity(pixUnity), .pixQuad(pixQuad),
		.pixMedium(pixMedium), .pixShort(pixShort), .pixChan(pixChan), .pixX(pixX),
		.pixY(pixY), .pixSafetyLine(pixSafetyLine), .outValid(outValid),
		.outReady(outReady), .outLong(outLong), .outMedium(outMedium),
		.outShort(outShort), .outChan(outChan), .mergeValid(mergeValid),
		.mergeIn(mergeIn), .mergeChan(mergeChan), .mergeOutValid(mergeOutValid),
		.mergeOut(mergeOut));
	////////////////////////////////////////////////////////////////
	// clock, and a cycle ceiling so a hang still reaches the verdict
	initial begin
		clock = 1'b0;
		forever #2 clock = ~clock;
	end
	always @(posedge clock) begin
		cyc++;
		if (cyc == 4000) begin
			err_total++;
			tally_and_finish;
		end
	end
	task automatic tally_and_finish;
		if (err_total == 0 && comparisons > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	task automatic chk(input logic [11:0] got, input logic [11:0] exp);
		comparisons++;
		if (got !== exp) begin
			err_total++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// one frame: start pulse, then one start pulse per line
	task automatic frame;
		@(posedge clock);
		#1;
		frameStart = 1'b1;
		@(posedge clock);
		#1;
		frameStart = 1'b0;
		repeat (200) begin
			@(posedge clock);
			#1;
			lineStart = 1'b1;
			@(posedge clock);
			#1;
			lineStart = 1'b0;
		end
	endtask
	// pattern control only lands on a standby to video_out_state step
	task automatic tp(input logic [7:0] c);
		streamOn = 1'b0;
		host.wr(`HGTP_ADDR_LAST, c);
		streamOn = 1'b1;
		@(posedge clock);
		#1;
	endtask
	// one pixel in; with the sink ready it shows one cycle later
	task automatic pix(input logic [11:0] x, u, q, input logic s, input logic [11:0] eL, eM);
		@(posedge clock);
		#1;
		pixX = x;
		pixY = x;
		pixUnity = u;
		pixQuad = q;
		pixMedium = u;
		pixShort = u;
		pixSafetyLine = s;
		pixValid = 1'b1;
		@(posedge clock);
		#1;
		pixValid = 1'b0;
		chk(outLong, eL);
		chk(outMedium, eM);
		chk(outShort, eM);
		chk(12'(outChan), 12'(pixChan));
	endtask
	task automatic mg(input logic [1:0] ch, input logic [11:0] v, e);
		@(posedge clock);
		#1;
		mergeValid = 1'b1;
		mergeIn = v;
		mergeChan = ch;
		@(posedge clock);
		#1;
		mergeValid = 1'b0;
		chk(mergeOut, e);
	endtask
	////////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		{resetn, frameStart, lineStart, streamOn, pixValid, mergeValid, pixSafetyLine} = '0;
		{pixUnity, pixQuad, pixMedium, pixShort, pixX, pixY, mergeIn} = '0;
		{pixChan, mergeChan} = '0;
		frameLenLines = 16'h00C8;
		outReady = 1'b1;
		repeat (3) @(posedge clock);
		#1;
		resetn = 1'b1;
		host.rd(`HGTP_ADDR_HOLD, d);
		chk(12'(d), 12'h000);
		host.rd(`HGTP_ADDR_LAST, d);
		chk(12'(d), 12'(`HGTP_TPC_RST));
		host.rd(16'h3002, d);
		chk(12'(d), 12'h001);
		host.rd(16'h0000, d);
		chk(12'(d), 12'h000);
		// reset pattern mode, then plain pass-through of the long merge
		streamOn = 1'b1;
		pix(12'h123, 12'h011, 12'h040, 1'b1, 12'h123, 12'h123);
		pix(12'h123, 12'h234, 12'hFFF, 1'b0, 12'h234, 12'h234);
		for (int i = 0; i < 11; i++) begin
			tp(cTab[i]);
			pix(xTab[i], 12'h011, 12'h040, 1'b0, eTab[i],
				eTab[i] == 12'h010 ? 12'h011 : eTab[i]);
		end
		tp(8'h02);
		host.wr(`HGTP_ADDR_LAST, 8'h00);
		pix(12'h000, 12'h011, 12'h040, 1'b0, 12'hFFF, 12'hFFF);
		// fill the buffer with the sink stalled, then drain it
		@(posedge clock);
		#1;
		outReady = 1'b0;
		pixValid = 1'b1;
		repeat (16) @(posedge clock);
		#1;
		pixValid = 1'b0;
		chk(12'(pixReady), 12'h000);
		outReady = 1'b1;
		repeat (16) @(posedge clock);
		#1;
		chk(12'(outValid), 12'h000);
		// grouped gain update held across frames, then released
		host.stage(4'hC, 1'b1, 16'h0200);
		host.wr(16'h3018, 8'h10);
		host.wr(16'h3010, 8'h0A);
		host.wr(16'h3011, 8'hBC);
		frame();
		frame();
		chk(12'(coarseGainCode), 12'h000);
		host.wr(`HGTP_ADDR_HOLD, 8'h00);
		frame();
		chk(12'(coarseGainCode), 12'h000);
		frame();
		chk(12'(coarseGainCode), 12'h00C);
		chk(12'(convGainHigh), 12'h001);
		mg(`HGTP_CH_R, 12'h100, 12'h200);
		mg(`HGTP_CH_R, 12'hFFF, 12'hFFF);
		mg(2'h0, 12'h123, 12'h123);
		// ramp lines, solid colour and prbs restart after the grouped commit
		tp(8'h40);
		pixChan = `HGTP_CH_R;
		pix(12'h00C, 12'h011, 12'h040, 1'b0, 12'h00C, 12'h00C);
		pix(12'h020, 12'h011, 12'h040, 1'b0, 12'h010, 12'h011);
		pixChan = 2'h0;
		tp(8'h01);
		pix(12'h300, 12'h011, 12'h040, 1'b0, 12'hABC, 12'hABC);
		tp(8'h13);
		frame();
		pix(12'h300, 12'h011, 12'h040, 1'b0, 12'h001, 12'h001);
		pix(12'h300, 12'h011, 12'h040, 1'b0, 12'h002, 12'h002);
		frame();
		pix(12'h300, 12'h011, 12'h040, 1'b0, 12'h001, 12'h001);
		tally_and_finish;
	end
endmodule
`default_nettype wire
